/* File: violation_report.sv */
// Violation report framer for protective function B with fieldbus status messages.
// Assumes a beam stream on clk, plug and config pins from outside the clock domain,
// and an AXI4-Lite master on clk.
//
// Functional notes
// R1 - Byte 38 carries signed warning-field hit angle, -135 to +135 degrees.
// R2 - Byte 40 carries unsigned warning-field hit distance, 0 to 20000 mm.
// R3 - Byte 42 carries signed protective-field hit angle, -135 to +135 degrees.
// R4 - Byte 44 carries unsigned protective-field hit distance, 0 to 8250 mm.
// R5 - Scanner unit plugged in during operation sends code 0x8181FF00.
// R6 - Scanner unit unplugged sends code 0x8181FF01; process data becomes invalid.
// R7 - First valid configuration load sends 0x8181FF03 and enters monitoring.
// R8 - Vendor-specific status messages may be sent to the controller.
// R9 - The first hit is the earliest violated beam in rotation order.
// R10 - Multi-byte fields go out most significant byte first.
`timescale 1ns/1ns
`default_nettype none

module violation_report
	import violation_report_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Beam stream from the measurement core.
	input  wire logic        scan_start,
	input  wire logic        scan_end,
	input  wire logic        beam_valid,
	input  wire logic        warn_hit,
	input  wire logic        guard_hit,
	input  wire logic [15:0] beam_angle,
	input  wire logic [15:0] beam_distance,
	// Asynchronous pins.
	input  wire logic        unit_present_pin,
	input  wire logic        config_valid_pin,
	// Telegram byte read port.
	input  wire logic [5:0]  tel_addr,
	output logic [7:0]       tel_data,
	output logic             tel_hit,
	// Status message output.
	output logic             stat_valid,
	input  wire logic        stat_ready,
	output logic [31:0]      stat_code,
	output logic             monitoring,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt.
	output logic             irq
);

	logic [1:0]             present_sync_reg;
	logic [1:0]             config_sync_reg;
	logic                   present_reg;
	logic                   config_reg;
	unit_state_type         state_reg;
	logic                   config_seen_reg;
	logic [31:0]            ctrl_reg;
	logic [31:0]            last_code_reg;
	logic [`IRQ_WIDTH-1:0]  irq_status_reg;
	logic [`IRQ_WIDTH-1:0]  irq_enable_reg;
	logic [15:0]            warn_hit_angle_b;
	logic [15:0]            warn_hit_distance_b;
	logic [15:0]            guard_hit_angle_b;
	logic [15:0]            guard_hit_distance_b;
	hit_type                warn_result;
	hit_type                guard_result;
	logic                   warn_stb;
	logic                   guard_stb;
	logic                   plug_evt;
	logic                   unplug_evt;
	logic                   config_evt;
	logic                   data_ok;
	logic                   stream_on;
	logic [7:0]             aw_addr_reg;
	logic                   aw_full_reg;
	logic [31:0]            w_data_reg;
	logic [3:0]             w_strb_reg;
	logic                   w_full_reg;
	logic                   wr_fire;
	logic [`IRQ_WIDTH-1:0]  irq_clear;
	logic [31:0]            ctrl_wr_mask;

	// Pins cross into clk through two flip-flops before any use.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			present_sync_reg <= 2'b00;
			config_sync_reg  <= 2'b00;
			present_reg      <= 1'b0;
			config_reg       <= 1'b0;
		end else begin
			present_sync_reg <= {present_sync_reg[0], unit_present_pin};
			config_sync_reg  <= {config_sync_reg[0], config_valid_pin};
			present_reg      <= present_sync_reg[1];
			config_reg       <= config_sync_reg[1];
		end
	end

	assign plug_evt   = present_sync_reg[1] && !present_reg;
	assign unplug_evt = !present_sync_reg[1] && present_reg;
	assign config_evt = config_sync_reg[1] && !config_reg && !config_seen_reg && present_reg;
	assign stream_on  = ctrl_reg[`CTRL_ENABLE_BIT] && data_ok;

	first_hit_capture warn_capture (
		.clk           (clk),
		.rst_n         (rst_n),
		.scan_start    (scan_start),
		.scan_end      (scan_end && stream_on),
		.beam_valid    (beam_valid && stream_on),
		.beam_hit      (warn_hit),
		.beam_angle    (beam_angle),
		.beam_distance (beam_distance),
		.distance_max  (`WARN_DIST_MAX),
		.result        (warn_result),
		.result_stb    (warn_stb)
	);

	first_hit_capture guard_capture (
		.clk           (clk),
		.rst_n         (rst_n),
		.scan_start    (scan_start),
		.scan_end      (scan_end && stream_on),
		.beam_valid    (beam_valid && stream_on),
		.beam_hit      (guard_hit),
		.beam_angle    (beam_angle),
		.beam_distance (beam_distance),
		.distance_max  (`GUARD_DIST_MAX),
		.result        (guard_result),
		.result_stb    (guard_stb)
	);

	// Unit lifecycle: absent, waiting for a valid configuration, monitoring.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg       <= unit_absent;
			config_seen_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				unit_absent: begin
					if (plug_evt) begin
						state_reg <= config_seen_reg ? unit_monitoring : unit_waiting_config;
					end
				end
				unit_waiting_config: begin
					if (unplug_evt) begin
						state_reg <= unit_absent;
					end else if (config_evt) begin
						state_reg       <= unit_monitoring; // R7
						config_seen_reg <= 1'b1;
					end
				end
				unit_monitoring: begin
					if (unplug_evt) begin
						state_reg <= unit_absent;
					end
				end
			endcase
			if (ctrl_wr_mask[`CTRL_RESTART_BIT]) begin
				config_seen_reg <= 1'b0;
			end
		end
	end

	assign data_ok    = (state_reg == unit_monitoring);
	assign monitoring = data_ok;

	// Status message offer; a new event replaces one not yet taken, newest wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_valid    <= 1'b0;
			stat_code     <= 32'h00000000;
			last_code_reg <= 32'h00000000;
		end else begin
			if (stat_valid && stat_ready) begin
				stat_valid <= 1'b0;
			end
			if (unplug_evt) begin // R8
				stat_valid    <= 1'b1;
				stat_code     <= `STAT_RESOURCE_GONE; // R6
				last_code_reg <= `STAT_RESOURCE_GONE;
			end else if (plug_evt) begin
				stat_valid    <= 1'b1;
				stat_code     <= `STAT_RESOURCE_BACK; // R5
				last_code_reg <= `STAT_RESOURCE_BACK;
			end else if (config_evt && state_reg == unit_waiting_config) begin
				stat_valid    <= 1'b1;
				stat_code     <= `STAT_CONFIG_CHANGED; // R7
				last_code_reg <= `STAT_CONFIG_CHANGED;
			end
		end
	end

	// Report fields; cleared when the unit stops delivering valid data.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			warn_hit_angle_b     <= `FIELD_INVALID;
			warn_hit_distance_b  <= `FIELD_INVALID;
			guard_hit_angle_b    <= `FIELD_INVALID;
			guard_hit_distance_b <= `FIELD_INVALID;
		end else if (!data_ok) begin
			warn_hit_angle_b     <= `FIELD_INVALID; // R6
			warn_hit_distance_b  <= `FIELD_INVALID;
			guard_hit_angle_b    <= `FIELD_INVALID;
			guard_hit_distance_b <= `FIELD_INVALID;
		end else begin
			if (warn_stb) begin
				warn_hit_angle_b    <= warn_result.found ? warn_result.angle : `FIELD_INVALID; // R1
				warn_hit_distance_b <= warn_result.found ? warn_result.distance : `FIELD_INVALID; // R2
			end
			if (guard_stb) begin
				guard_hit_angle_b    <= guard_result.found ? guard_result.angle : `FIELD_INVALID; // R3
				guard_hit_distance_b <= guard_result.found ? guard_result.distance : `FIELD_INVALID; // R4
			end
		end
	end

	// Telegram byte port, big-endian fields.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tel_data <= 8'h00;
			tel_hit  <= 1'b0;
		end else begin
			tel_hit <= (tel_addr >= `TEL_FIRST_BYTE) && (tel_addr <= `TEL_LAST_BYTE);
			unique case (tel_addr)
				`TEL_WARN_ANGLE_BYTE:          tel_data <= warn_hit_angle_b[15:8]; // R10
				`TEL_WARN_ANGLE_BYTE + 6'd1:   tel_data <= warn_hit_angle_b[7:0];
				`TEL_WARN_DIST_BYTE:           tel_data <= warn_hit_distance_b[15:8];
				`TEL_WARN_DIST_BYTE + 6'd1:    tel_data <= warn_hit_distance_b[7:0];
				`TEL_GUARD_ANGLE_BYTE:         tel_data <= guard_hit_angle_b[15:8];
				`TEL_GUARD_ANGLE_BYTE + 6'd1:  tel_data <= guard_hit_angle_b[7:0];
				`TEL_GUARD_DIST_BYTE:          tel_data <= guard_hit_distance_b[15:8];
				`TEL_GUARD_DIST_BYTE + 6'd1:   tel_data <= guard_hit_distance_b[7:0];
				default:                       tel_data <= 8'h00;
			endcase
		end
	end

	// AXI write path: address and data are held independently until both are in.
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	assign wr_fire       = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg  <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_full_reg   <= 1'b0;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr_reg)
					`REG_CTRL, `REG_IRQ_ENABLE, `REG_IRQ_CLEAR: s_axi_bresp <= `AXI_RESP_OKAY;
					default:                                   s_axi_bresp <= `AXI_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			strb_mask[i*8 +: 8] = {8{strb[i]}};
		end
	endfunction

	assign ctrl_wr_mask = (wr_fire && aw_addr_reg == `REG_CTRL) ? (w_data_reg & strb_mask(w_strb_reg)) : 32'h0;
	assign irq_clear    = (wr_fire && aw_addr_reg == `REG_IRQ_CLEAR) ? w_data_reg[`IRQ_WIDTH-1:0] : '0;

	// The restart bit is a self-clearing strobe and never stored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg       <= `CTRL_RESET;
			irq_enable_reg <= '0;
		end else if (wr_fire) begin
			if (aw_addr_reg == `REG_CTRL) begin
				ctrl_reg <= ((ctrl_reg & ~strb_mask(w_strb_reg)) | ctrl_wr_mask) & 32'h00000001;
			end
			if (aw_addr_reg == `REG_IRQ_ENABLE && w_strb_reg[0]) begin
				irq_enable_reg <= w_data_reg[`IRQ_WIDTH-1:0];
			end
		end
	end

	// Sticky events; a set in the same cycle as its clear wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | {
				guard_stb && guard_result.found && data_ok,
				warn_stb && warn_result.found && data_ok,
				config_evt && state_reg == unit_waiting_config,
				unplug_evt,
				plug_evt
			};
		end
	end

	assign irq = |(irq_status_reg & irq_enable_reg);

	// AXI read path: one cycle to answer.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `AXI_RESP_OKAY;
			unique case (s_axi_araddr)
				`REG_CTRL:       s_axi_rdata <= ctrl_reg;
				`REG_STATE:      s_axi_rdata <= {27'h0, config_seen_reg, present_reg, data_ok, state_reg};
				`REG_WARN:       s_axi_rdata <= {warn_hit_angle_b, warn_hit_distance_b};
				`REG_GUARD:      s_axi_rdata <= {guard_hit_angle_b, guard_hit_distance_b};
				`REG_LAST_CODE:  s_axi_rdata <= last_code_reg;
				`REG_IRQ_STATUS: s_axi_rdata <= {27'h0, irq_status_reg};
				`REG_IRQ_ENABLE: s_axi_rdata <= {27'h0, irq_enable_reg};
				`REG_IRQ_CLEAR:  s_axi_rdata <= 32'h00000000;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `AXI_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: violation_report_cfg.svh */
// Offsets, codes, reset values and field positions of the violation report framer.
// Assumes it is included by bare name from the package and the testbench files.
`ifndef VIOLATION_REPORT_CFG_SVH
`define VIOLATION_REPORT_CFG_SVH

// Telegram byte positions of the four report fields.
`define TEL_WARN_ANGLE_BYTE      6'd38
`define TEL_WARN_DIST_BYTE       6'd40
`define TEL_GUARD_ANGLE_BYTE     6'd42
`define TEL_GUARD_DIST_BYTE      6'd44
`define TEL_FIRST_BYTE           6'd38
`define TEL_LAST_BYTE            6'd45

// Value limits of the fields.
`define ANGLE_MIN                16'shff79
`define ANGLE_MAX                16'sh0087
`define WARN_DIST_MAX            16'h4e20
`define GUARD_DIST_MAX           16'h203a

// Status message codes.
`define STAT_RESOURCE_BACK       32'h8181ff00
`define STAT_RESOURCE_GONE       32'h8181ff01
`define STAT_CONFIG_CHANGED      32'h8181ff03

// Register byte addresses on the AXI4-Lite slave.
`define REG_CTRL                 8'h00
`define REG_STATE                8'h04
`define REG_WARN                 8'h08
`define REG_GUARD                8'h0c
`define REG_LAST_CODE            8'h10
`define REG_IRQ_STATUS           8'h14
`define REG_IRQ_ENABLE           8'h18
`define REG_IRQ_CLEAR            8'h1c

// Control register fields.
`define CTRL_ENABLE_BIT          0
`define CTRL_RESTART_BIT         1
`define CTRL_RESET               32'h00000001

// Interrupt status bit positions.
`define IRQ_PLUG_BIT             0
`define IRQ_UNPLUG_BIT           1
`define IRQ_CONFIG_BIT           2
`define IRQ_WARN_BIT             3
`define IRQ_GUARD_BIT            4
`define IRQ_WIDTH                5

// Invalid-data filler for angle and distance fields.
`define FIELD_INVALID            16'h0000

`define AXI_RESP_OKAY            2'b00
`define AXI_RESP_SLVERR          2'b10

`endif

/* File: violation_report_pkg.sv */
// Types shared by the violation report framer files.
// Assumes the constants header sits in the same folder.
`include "violation_report_cfg.svh"

package violation_report_pkg;

	typedef enum logic [1:0] {
		unit_absent,
		unit_waiting_config,
		unit_monitoring
	} unit_state_type;

	typedef struct packed {
		logic        found;
		logic [15:0] angle;
		logic [15:0] distance;
	} hit_type;

endpackage

/* File: first_hit_capture.sv */
// Finds the first violated beam of one field over a scan sweep.
// Assumes beams arrive in rotation order, one per beam_valid, framed by scan_start.
`timescale 1ns/1ns
`default_nettype none

module first_hit_capture
	import violation_report_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Beam stream.
	input  wire logic        scan_start,
	input  wire logic        scan_end,
	input  wire logic        beam_valid,
	input  wire logic        beam_hit,
	input  wire logic [15:0] beam_angle,
	input  wire logic [15:0] beam_distance,
	input  wire logic [15:0] distance_max,
	// Result of the last completed sweep.
	output var  hit_type     result,
	output logic             result_stb
);

	hit_type sweep_reg;

	function automatic logic angle_ok(input logic [15:0] a);
		angle_ok = ($signed(a) >= `ANGLE_MIN) && ($signed(a) <= `ANGLE_MAX);
	endfunction

	// Only the earliest hit of the sweep inside the angle limits is kept; later hits are ignored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sweep_reg <= '0;
		end else if (scan_start) begin
			sweep_reg <= '0;
		end else if (beam_valid && beam_hit && !sweep_reg.found && angle_ok(beam_angle)) begin // R9
			sweep_reg.found    <= 1'b1;
			sweep_reg.angle    <= beam_angle;
			sweep_reg.distance <= (beam_distance > distance_max) ? distance_max : beam_distance;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result     <= '0;
			result_stb <= 1'b0;
		end else begin
			result_stb <= scan_end;
			if (scan_end) begin
				result <= sweep_reg;
			end
		end
	end

endmodule

`default_nettype wire

/* File: violation_report_props.sv */
// Concurrent checks on the ports of the violation report framer.
// Assumes it is bound into the framer, whose port names it shares.
`timescale 1ns/1ns
`default_nettype none

module violation_report_props (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst_n,
	// Watched ports.
	input wire logic        unit_present_pin,
	input wire logic [5:0]  tel_addr,
	input wire logic [7:0]  tel_data,
	input wire logic        tel_hit,
	input wire logic        stat_valid,
	input wire logic        stat_ready,
	input wire logic [31:0] stat_code,
	input wire logic        monitoring
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence offer(logic [31:0] c);
		stat_valid && stat_code == c;
	endsequence
	sequence unit_lost;
		$fell(unit_present_pin);
	endsequence

	AST_PLUG_CODE: assert property ($rose(unit_present_pin) |-> ##[2:5] offer(32'h8181ff00))
		else $error("plug message missing");
	AST_STAT_HOLD: assert property (stat_valid && !stat_ready |=> stat_valid)
		else $error("status offer dropped early");
	AST_UNPLUG_CODE: assert property (unit_lost |-> ##[2:5] offer(32'h8181ff01))
		else $error("unplug message missing");
	AST_UNPLUG_STOPS: assert property (unit_lost |-> ##5 !monitoring)
		else $error("still monitoring without unit");
	AST_INVALID_ZERO: assert property (!monitoring [*3] |-> !tel_hit || tel_data == 8'h00)
		else $error("telegram data while not valid");
	AST_MON_OFFER: assert property ($rose(monitoring) |-> ##[0:1] stat_valid &&
		stat_code inside {32'h8181ff00, 32'h8181ff03})
		else $error("monitoring entered without message");
	AST_STAT_LEGAL: assert property (stat_valid |-> stat_code inside {32'h8181ff00, 32'h8181ff01,
		32'h8181ff03})
		else $error("unknown status code offered");
	AST_TEL_WINDOW: assert property (1'b1 |-> tel_hit == ($past(tel_addr) inside {[6'd38:6'd45]}))
		else $error("telegram window wrong");
endmodule

`default_nettype wire

/* File: status_sink_model.sv */
// Model of the safety controller that takes status messages from the framer.
// Assumes a valid and ready handshake on the framer clock.
`timescale 1ns/1ns
`default_nettype none

module status_sink_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Pacing.
	input  wire logic        slow,
	// Status message channel.
	input  wire logic        stat_valid,
	input  wire logic [31:0] stat_code,
	output logic             stat_ready,
	// Last message taken and the running count.
	output logic [31:0]      got_code,
	output logic [7:0]       got_cnt
);
	logic [1:0] phase_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	// A slow listener takes one cycle in four, so the framer must keep its offer standing.
	assign stat_ready = !slow || phase_reg == 2'h3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			got_code <= 32'h0;
			got_cnt  <= 8'h0;
		end else if (stat_valid && stat_ready) begin
			got_code <= stat_code;
			got_cnt  <= got_cnt + 8'h1;
		end
	end
endmodule

`default_nettype wire

/* File: violation_report_tb.sv */
// Self-checking bench for the violation report framer.
// Assumes the design, its package, the checker and the status sink model compile first.
`timescale 1ns/1ns
`default_nettype none
`include "violation_report_cfg.svh"

module violation_report_tb;
	logic        clk, rst_n, scan_start, scan_end, beam_valid, warn_hit, guard_hit;
	logic [15:0] beam_angle, beam_distance;
	logic        unit_present_pin, config_valid_pin, tel_hit, stat_valid, stat_ready, monitoring, irq, slow;
	logic [5:0]  tel_addr;
	logic [7:0]  tel_data, got_cnt, s_axi_awaddr, s_axi_araddr;
	logic [31:0] stat_code, got_code, s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          n_fail, tests_run;

	violation_report DUT (.*);
	status_sink_model u_sink (.*);

	always #20 clk = !clk;

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] e, input logic [31:0] got);
		tests_run++;
		if (got !== e) begin
			$display("BAD %s expected %h seen %h", name, e, got);
			n_fail++;
		end
	endtask

	// One bus cycle; ready and valid are looked at 1 ns after the edge before the one that takes them.
	task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic [1:0] rs);
		bit a_t, w_t, b_t;
		int i;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_araddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid  <= wr;
		s_axi_bready  <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready  <= !wr;
		b_t = 1'b0;
		for (i = 0; i < 40 && !b_t; i++) begin
			#1;
			a_t = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = wr ? s_axi_bready && s_axi_bvalid : s_axi_rready && s_axi_rvalid;
			rs = wr ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge clk);
			if (a_t) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (w_t) begin
				s_axi_wvalid <= 1'b0;
			end
			if (b_t) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end
		if (!b_t) begin
			n_fail++;
			results();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  rs;
		bus(1'b0, a, 32'h0, q, rs);
		check("read data", e, q);
		check("read response", {30'h0, er}, {30'h0, rs});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  rs;
		bus(1'b1, a, d, q, rs);
		check("write response", {30'h0, er}, {30'h0, rs});
	endtask

	task automatic tel(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		tel_addr <= a;
		@(posedge clk);
		#1;
		check("telegram byte", {24'h0, e}, {24'h0, tel_data});
	endtask

	// Flags are start, end, valid, warning hit, guard hit from the top bit down.
	task automatic beam(input logic [4:0] f, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		{scan_start, scan_end, beam_valid, warn_hit, guard_hit} <= f;
		beam_angle    <= a;
		beam_distance <= d;
	endtask

	task automatic evt(input logic p, input logic c, input logic [31:0] e);
		logic [7:0] n0;
		int i;
		n0 = got_cnt;
		@(posedge clk);
		unit_present_pin <= p;
		config_valid_pin <= c;
		for (i = 0; i < 60 && got_cnt == n0; i++) begin
			@(posedge clk);
		end
		#1;
		check("message count", {24'h0, n0 + 8'h1}, {24'h0, got_cnt});
		check("status code", e, got_code);
		if (got_cnt == n0) begin
			results();
		end
	endtask

	task automatic t_attach();
		evt(1'b1, 1'b0, `STAT_RESOURCE_BACK);
		check("monitoring", 32'h0, {31'h0, monitoring});
		evt(1'b1, 1'b1, `STAT_CONFIG_CHANGED);
		check("monitoring", 32'h1, {31'h0, monitoring});
		$display("test attach done");
	endtask

	task automatic t_sweep();
		logic [63:0] e;
		int i;
		e = {`ANGLE_MIN, `WARN_DIST_MAX, `ANGLE_MAX, `GUARD_DIST_MAX};
		wr(`REG_IRQ_ENABLE, 32'h18, `AXI_RESP_OKAY);
		check("irq", 32'h0, {31'h0, irq});
		beam(5'h10, 16'h0, 16'h0);
		beam(5'h07, 16'hff38, 16'h0064);
		beam(5'h06, 16'hff79, 16'h61a8);
		beam(5'h06, 16'h0000, 16'h0064);
		beam(5'h05, 16'h0087, 16'h2328);
		beam(5'h05, 16'h0088, 16'h0064);
		beam(5'h08, 16'h0, 16'h0);
		beam(5'h00, 16'h0, 16'h0);
		repeat (3) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			tel(6'd38 + 6'(i), e[63 - 8 * i -: 8]);
		end
		rd(`REG_WARN, e[63:32], `AXI_RESP_OKAY);
		rd(`REG_GUARD, e[31:0], `AXI_RESP_OKAY);
		check("irq", 32'h1, {31'h0, irq});
		$display("test sweep done");
	endtask

	task automatic t_regs();
		rd(`REG_CTRL, `CTRL_RESET, `AXI_RESP_OKAY);
		rd(`REG_IRQ_STATUS, 32'h1d, `AXI_RESP_OKAY);
		wr(`REG_IRQ_CLEAR, 32'h18, `AXI_RESP_OKAY);
		check("irq", 32'h0, {31'h0, irq});
		rd(`REG_IRQ_STATUS, 32'h05, `AXI_RESP_OKAY);
		wr(`REG_IRQ_STATUS, 32'h1f, `AXI_RESP_SLVERR);
		rd(8'h20, 32'h0, `AXI_RESP_SLVERR);
		rd(`REG_LAST_CODE, `STAT_CONFIG_CHANGED, `AXI_RESP_OKAY);
		$display("test registers done");
	endtask

	task automatic t_detach();
		logic [7:0] n0;
		@(posedge clk);
		slow <= 1'b1;
		evt(1'b0, 1'b1, `STAT_RESOURCE_GONE);
		check("monitoring", 32'h0, {31'h0, monitoring});
		tel(6'd38, 8'h00);
		rd(`REG_WARN, 32'h0, `AXI_RESP_OKAY);
		evt(1'b1, 1'b1, `STAT_RESOURCE_BACK);
		check("monitoring", 32'h1, {31'h0, monitoring});
		n0 = got_cnt;
		@(posedge clk);
		config_valid_pin <= 1'b0;
		repeat (4) @(posedge clk);
		config_valid_pin <= 1'b1;
		repeat (12) @(posedge clk);
		check("message count", {24'h0, n0}, {24'h0, got_cnt});
		$display("test detach done");
	endtask

	// A sweep while streaming is off must leave the fields alone; restart re-arms the first config.
	task automatic t_ctrl();
		wr(`REG_CTRL, 32'h0, `AXI_RESP_OKAY);
		beam(5'h10, 16'h0, 16'h0);
		beam(5'h06, 16'h0010, 16'h0100);
		beam(5'h08, 16'h0, 16'h0);
		beam(5'h00, 16'h0, 16'h0);
		repeat (3) @(posedge clk);
		rd(`REG_WARN, 32'h0, `AXI_RESP_OKAY);
		wr(`REG_CTRL, 32'h3, `AXI_RESP_OKAY);
		rd(`REG_CTRL, `CTRL_RESET, `AXI_RESP_OKAY);
		rd(`REG_STATE, 32'h0e, `AXI_RESP_OKAY);
		$display("test control done");
	endtask

	initial begin
		{clk, rst_n, scan_start, scan_end, beam_valid, warn_hit, guard_hit} = 7'h0;
		{beam_angle, beam_distance, tel_addr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{unit_present_pin, config_valid_pin, slow, s_axi_awvalid, s_axi_wvalid} = 5'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		s_axi_wstrb = 4'hf;
		n_fail = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_attach();
		t_sweep();
		t_regs();
		t_detach();
		t_ctrl();
		results();
	end
endmodule

bind violation_report violation_report_props u_props (.*);

`default_nettype wire
